// >>> logic/tms_defines.vh
// constants for the timer master-trigger selection block
// What this block does
// R1: select bit picks channel1 pin or hall xor
// R2: three-bit master mode picks trigger output
// R3: code 000 forwards software update-generate bit
// R4: reset mode via trigger input delays output
// R5: code 001 forwards counter enable signal
// R6: gated enable lags unless master/slave sync set
// R7: code 010 forwards update event
// R8: code 011 pulses on every channel1 flag event
// R9: code 100 forwards compare1 reference
// R10: 110 compare2, 111 compare3, 101 undefined
// R11: slave-mode register field layout, reserved bits zero
// R12: both registers reset zero, reserved read zero
// R13: pulse modes last one clock per event
`ifndef TMS_DEFINES_VH
`define TMS_DEFINES_VH
// ----------------------------------------
// addresses
// ----------------------------------------
`define TMS_T1_CTRL2_ADDR  32'h4000E004
`define TMS_T1_SMCR_ADDR   32'h4000E008
`define TMS_T2_CTRL2_ADDR  32'h4000F004
`define TMS_T2_SMCR_ADDR   32'h4000F008
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TMS_TI1S_BIT       7
`define TMS_MMS_HI         6
`define TMS_MMS_LO         4
`define TMS_CTRL2_MASK     32'h000000F0
`define TMS_SMCR_MASK      32'h0000FFF7
`define TMS_MSM_BIT        7
`define TMS_REG_RESET      32'h00000000
// ----------------------------------------
// master mode codes
// ----------------------------------------
`define TMS_MM_RESET       3'h0
`define TMS_MM_ENABLE      3'h1
`define TMS_MM_UPDATE      3'h2
`define TMS_MM_CPULSE      3'h3
`define TMS_MM_OC1         3'h4
`define TMS_MM_OC2         3'h6
`define TMS_MM_OC3         3'h7
`endif

// >>> logic/tms_trigger_mux.v
// one timer's master trigger selection and channel 1 input select
`default_nettype none
`include "tms_defines.vh"
module tms_trigger_mux (
   input  wire       clk,
   input  wire       reset_n,
   input  wire [2:0] master_mode_select,
   input  wire       master_slave_sync,
   input  wire       channel1_input_select,
   input  wire       update_generate_bit,
   input  wire       slave_reset_from_trigger,
   input  wire       counter_enable_signal,
   input  wire       enable_from_trigger,
   input  wire       update_event,
   input  wire       channel1_flag_event,
   input  wire       compare1_reference,
   input  wire       compare2_reference,
   input  wire       compare3_reference,
   input  wire       channel1_pin_input,
   input  wire [2:0] hall_sensor_inputs,
   output reg        trigger_output,
   output reg        channel1_filter_input
);
   // ----------------------------------------
   // delay stage for trigger-driven paths
   // ----------------------------------------
   reg ug_dly_r;
   reg en_dly_r;
   reg trig_nxt;
   always @(posedge clk) begin
      if (!reset_n) begin
         ug_dly_r <= 1'b0;
         en_dly_r <= 1'b0;
      end else begin
         ug_dly_r <= update_generate_bit;
         en_dly_r <= counter_enable_signal;
      end
   end
   always @* begin
      case (master_mode_select) // R2
         // hardware reset from trigger input shows one clock later
         `TMS_MM_RESET:  trig_nxt = slave_reset_from_trigger ? ug_dly_r : update_generate_bit; // R3 R4
         // sync bit removes lag so master and slave start together
         `TMS_MM_ENABLE: trig_nxt = (enable_from_trigger && !master_slave_sync) ?
                                    en_dly_r : counter_enable_signal; // R5 R6
         `TMS_MM_UPDATE: trig_nxt = update_event; // R7 R13
         `TMS_MM_CPULSE: trig_nxt = channel1_flag_event; // R8 R13
         `TMS_MM_OC1:    trig_nxt = compare1_reference; // R9
         `TMS_MM_OC2:    trig_nxt = compare2_reference; // R10
         `TMS_MM_OC3:    trig_nxt = compare3_reference; // R10
         default:        trig_nxt = 1'b0; // R10
      endcase
   end
   always @(posedge clk) begin
      if (!reset_n) begin
         trigger_output        <= 1'b0;
         channel1_filter_input <= 1'b0;
      end else begin
         trigger_output        <= trig_nxt;
         channel1_filter_input <= channel1_input_select ? ^hall_sensor_inputs : channel1_pin_input; // R1
      end
   end
endmodule
`default_nettype wire

// >>> logic/tms_apb_regs.v
// apb register file for both timers' control 2 and slave-mode registers
`default_nettype none
`include "tms_defines.vh"
module tms_apb_regs (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [31:0] t1_ctrl2_r,
   output reg  [31:0] t1_smcr_r,
   output reg  [31:0] t2_ctrl2_r,
   output reg  [31:0] t2_smcr_r
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire setup  = psel && !penable;
   wire hit1c  = (paddr == `TMS_T1_CTRL2_ADDR);
   wire hit1s  = (paddr == `TMS_T1_SMCR_ADDR);
   wire hit2c  = (paddr == `TMS_T2_CTRL2_ADDR);
   wire hit2s  = (paddr == `TMS_T2_SMCR_ADDR);
   wire mapped = hit1c | hit1s | hit2c | hit2s;
   // writes land only at the edge that completes the access, never at setup
   wire access = psel && penable && pready;
   // no wait state: answer is registered in the setup cycle, given in access
   always @(posedge clk) begin
      if (!reset_n) begin
         t1_ctrl2_r <= `TMS_REG_RESET; // R12
         t1_smcr_r  <= `TMS_REG_RESET; // R12
         t2_ctrl2_r <= `TMS_REG_RESET; // R12
         t2_smcr_r  <= `TMS_REG_RESET; // R12
         prdata     <= 32'h00000000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= 32'h00000000;
         if (access && pwrite) begin
            if (hit1c) t1_ctrl2_r <= pwdata & `TMS_CTRL2_MASK; // R12
            if (hit1s) t1_smcr_r  <= pwdata & `TMS_SMCR_MASK; // R11
            if (hit2c) t2_ctrl2_r <= pwdata & `TMS_CTRL2_MASK; // R12
            if (hit2s) t2_smcr_r  <= pwdata & `TMS_SMCR_MASK; // R11
         end
         if (setup && !pwrite) begin
            if (hit1c) prdata <= t1_ctrl2_r;
            if (hit1s) prdata <= t1_smcr_r;
            if (hit2c) prdata <= t2_ctrl2_r;
            if (hit2s) prdata <= t2_smcr_r;
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/tms_top.v
// top: apb registers and master trigger selection for two timers
//
// Chosen here: the APB register port.
`default_nettype none
`include "tms_defines.vh"
module tms_top (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [1:0]  update_generate_bit,
   input  wire [1:0]  slave_reset_from_trigger,
   input  wire [1:0]  counter_enable_signal,
   input  wire [1:0]  enable_from_trigger,
   input  wire [1:0]  update_event,
   input  wire [1:0]  channel1_flag_event,
   input  wire [1:0]  compare1_reference,
   input  wire [1:0]  compare2_reference,
   input  wire [1:0]  compare3_reference,
   input  wire [1:0]  channel1_pin_input,
   input  wire [5:0]  hall_sensor_inputs,
   output wire [1:0]  trigger_output,
   output wire [1:0]  channel1_filter_input,
   output wire [31:0] t1_smcr_out,
   output wire [31:0] t2_smcr_out
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   wire [31:0] c1;
   wire [31:0] c2;
   tms_apb_regs u_regs (
      .clk        (clk),
      .reset_n    (reset_n),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .t1_ctrl2_r (c1),
      .t1_smcr_r  (t1_smcr_out),
      .t2_ctrl2_r (c2),
      .t2_smcr_r  (t2_smcr_out)
   );
   // ----------------------------------------
   // per-timer trigger selection
   // ----------------------------------------
   tms_trigger_mux u_t1 (
      .clk                      (clk),
      .reset_n                  (reset_n),
      .master_mode_select       (c1[`TMS_MMS_HI:`TMS_MMS_LO]),
      .master_slave_sync        (t1_smcr_out[`TMS_MSM_BIT]),
      .channel1_input_select    (c1[`TMS_TI1S_BIT]),
      .update_generate_bit      (update_generate_bit[0]),
      .slave_reset_from_trigger (slave_reset_from_trigger[0]),
      .counter_enable_signal    (counter_enable_signal[0]),
      .enable_from_trigger      (enable_from_trigger[0]),
      .update_event             (update_event[0]),
      .channel1_flag_event      (channel1_flag_event[0]),
      .compare1_reference       (compare1_reference[0]),
      .compare2_reference       (compare2_reference[0]),
      .compare3_reference       (compare3_reference[0]),
      .channel1_pin_input       (channel1_pin_input[0]),
      .hall_sensor_inputs       (hall_sensor_inputs[2:0]),
      .trigger_output           (trigger_output[0]),
      .channel1_filter_input    (channel1_filter_input[0])
   );
   tms_trigger_mux u_t2 (
      .clk                      (clk),
      .reset_n                  (reset_n),
      .master_mode_select       (c2[`TMS_MMS_HI:`TMS_MMS_LO]),
      .master_slave_sync        (t2_smcr_out[`TMS_MSM_BIT]),
      .channel1_input_select    (c2[`TMS_TI1S_BIT]),
      .update_generate_bit      (update_generate_bit[1]),
      .slave_reset_from_trigger (slave_reset_from_trigger[1]),
      .counter_enable_signal    (counter_enable_signal[1]),
      .enable_from_trigger      (enable_from_trigger[1]),
      .update_event             (update_event[1]),
      .channel1_flag_event      (channel1_flag_event[1]),
      .compare1_reference       (compare1_reference[1]),
      .compare2_reference       (compare2_reference[1]),
      .compare3_reference       (compare3_reference[1]),
      .channel1_pin_input       (channel1_pin_input[1]),
      .hall_sensor_inputs       (hall_sensor_inputs[5:3]),
      .trigger_output           (trigger_output[1]),
      .channel1_filter_input    (channel1_filter_input[1])
   );
endmodule
`default_nettype wire

// >>> tb/tms_trigger_properties.sv
// concurrent checks on the trigger selection top ports
`default_nettype none
module tms_trigger_checker (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [1:0]  update_generate_bit,
   input wire logic [1:0]  slave_reset_from_trigger,
   input wire logic [1:0]  counter_enable_signal,
   input wire logic [1:0]  enable_from_trigger,
   input wire logic [1:0]  update_event,
   input wire logic [1:0]  channel1_pin_input,
   input wire logic [5:0]  hall_sensor_inputs,
   input wire logic [1:0]  trigger_output,
   input wire logic [1:0]  channel1_filter_input,
   input wire logic [31:0] t1_smcr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] m_r;
   logic       s_r;
   // timer 1 mode copy, taken at the completing access edge just as the register is
   always @(posedge clk) begin
      if (!reset_n) begin
         m_r <= 3'h0;
         s_r <= 1'b0;
      end else if (psel && penable && pready && pwrite && paddr == 32'h4000E004) begin
         m_r <= pwdata[6:4];
         s_r <= pwdata[7];
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_ready_one_cycle: assert property (psel && !penable |=> pready) else $error("no pready");
   a_smcr_reserved_zero: assert property (t1_smcr_out[31:16] == 16'h0000 && !t1_smcr_out[3])
      else $error("reserved set");
   a_filter_select: assert property (channel1_filter_input[0] == ($past(s_r) ? ^$past(hall_sensor_inputs[2:0])
      : $past(channel1_pin_input[0]))) else $error("filter input");
   a_mode_reset: assert property ($past(m_r) == 3'h0 && !$past(slave_reset_from_trigger[0])
      |-> trigger_output[0] == $past(update_generate_bit[0])) else $error("mode 0");
   a_reset_delay: assert property ($past(m_r, 2) == 3'h0 && $past(m_r) == 3'h0 && $past(slave_reset_from_trigger[0])
      |-> trigger_output[0] == $past(update_generate_bit[0], 2)) else $error("mode 0 delay");
   a_mode_enable: assert property ($past(m_r) == 3'h1 && !($past(enable_from_trigger[0]) && !$past(t1_smcr_out[7]))
      |-> trigger_output[0] == $past(counter_enable_signal[0])) else $error("mode 1");
   a_enable_delay: assert property ($past(m_r, 2) == 3'h1 && $past(m_r) == 3'h1 && $past(enable_from_trigger[0])
      && !$past(t1_smcr_out[7]) |-> trigger_output[0] == $past(counter_enable_signal[0], 2)) else $error("mode 1 delay");
   a_mode_update: assert property ($past(m_r) == 3'h2 |-> trigger_output[0] == $past(update_event[0]))
      else $error("mode 2");
endmodule
bind tms_top tms_trigger_checker u_chk (
   .clk                      (clk),
   .reset_n                  (reset_n),
   .psel                     (psel),
   .penable                  (penable),
   .pwrite                   (pwrite),
   .paddr                    (paddr),
   .pwdata                   (pwdata),
   .pready                   (pready),
   .update_generate_bit      (update_generate_bit),
   .slave_reset_from_trigger (slave_reset_from_trigger),
   .counter_enable_signal    (counter_enable_signal),
   .enable_from_trigger      (enable_from_trigger),
   .update_event             (update_event),
   .channel1_pin_input       (channel1_pin_input),
   .hall_sensor_inputs       (hall_sensor_inputs),
   .trigger_output           (trigger_output),
   .channel1_filter_input    (channel1_filter_input),
   .t1_smcr_out              (t1_smcr_out)
);
`default_nettype wire

// >>> tb/tms_slave_model.sv
// slave timer model counting trigger events from the master
`default_nettype none
module tms_slave_model (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        trigger_in,
   output var  logic [15:0] event_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // every high clock is one event, so a stretched pulse would count twice
   always @(posedge clk) begin
      if (!reset_n)
         event_count <= 16'h0000;
      else if (trigger_in)
         event_count <= event_count + 16'h0001;
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// random and corner tests of the trigger selection top
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, er, ti, ms;
   logic [31:0] paddr = 0, pwdata = 0, rd, r;
   logic [31:0] ad[4] = '{32'h4000E004, 32'h4000E008, 32'h4000F004, 32'h4000F008};
   logic [23:0] v = 0, h1 = 0, h2 = 0;
   logic [2:0]  md;
   logic [1:0]  srt = 0, eft = 0;
   wire  [31:0] prdata, s1, s2;
   wire  [15:0] cnt;
   wire  [1:0]  trig, filt;
   wire         pready, pslverr;
   int          n_errors = 0, checked = 0, c0, e;
   tms_top DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .update_generate_bit(v[1:0]),
      .slave_reset_from_trigger(srt), .counter_enable_signal(v[3:2]), .enable_from_trigger(eft),
      .update_event(v[5:4]), .channel1_flag_event(v[7:6]), .compare1_reference(v[9:8]),
      .compare2_reference(v[13:12]), .compare3_reference(v[15:14]), .channel1_pin_input(v[17:16]),
      .hall_sensor_inputs(v[23:18]), .trigger_output(trig), .channel1_filter_input(filt), .t1_smcr_out(s1),
      .t2_smcr_out(s2));
   tms_slave_model P (.clk(clk), .reset_n(reset_n), .trigger_in(trig[0]), .event_count(cnt));
   initial forever #5 clk = ~clk;
   task chk(input logic [31:0] g, x);
      checked++;
      if (g !== x) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no cycle count assumed: only the watchdog ends a wait that never answers
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // sources sit at bit 2*mode, so one slice serves all plain modes
   function automatic logic f(input int i);
      case (md)
         3'h0: return srt[i] ? h2[i] : h1[i];
         3'h1: return (eft[i] && !ms) ? h2[2 + i] : h1[2 + i];
         3'h5: return 1'b0;
         default: return h1[2 * md + i];
      endcase
   endfunction
   task print_verdict;
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      print_verdict;
   end
   initial begin
      void'($urandom(52));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      foreach (ad[i]) begin
         apb(0, ad[i], 0);
         chk(rd, 0);
         apb(1, ad[i], '1);
         apb(0, ad[i], 0);
         chk(rd, i % 2 ? 32'h0000FFF7 : 32'h000000F0);
      end
      apb(1, 32'h4000E00C, '1);
      chk(er, 1);
      for (int k = 0; k < 16; k++) begin
         md = k[2:0];
         ms = k[3];
         r = $urandom;
         ti = r[0];
         @(posedge clk);
         // timer 2 sees gated enable with the sync bit set, timer 1 without it
         srt <= {~k[3], k[3]};
         eft <= {k[3], ~k[3]};
         for (int t = 0; t < 4; t++)
            apb(1, ad[t], t % 2 ? {24'h0, ms, 7'h0} : {24'h0, ti, md, 4'h0});
         e = 0;
         // sources stood still through the writes, so the delayed copy equals the last one
         h2 = h1;
         for (int j = 0; j < 40; j++) begin
            @(posedge clk);
            r = $urandom;
            v <= r[23:0];
            #1;
            for (int i = 0; i < 2; i++) begin
               chk(trig[i], f(i));
               chk(filt[i], ti ? ^h1[18 + 3 * i +: 3] : h1[16 + i]);
            end
            if (j == 0) begin
               c0 = cnt;
               chk(s1, {24'h0, ms, 7'h0});
               chk(s2, {24'h0, ms, 7'h0});
            end
            if (j == 39)
               chk(cnt - c0, e);
            e += f(0);
            h2 = h1;
            h1 = r[23:0];
         end
      end
      print_verdict;
   end
endmodule
`default_nettype wire
